// ==== inc/ptc_consts.svh ====
// register map, field positions, reset values and widths of the periodic timer
//
// How it works
// - mode field: 00 compare, 01 undefined, 10 pwm/single pulse, 11 timer
// - compare A match in compare mode: keep, drive low, drive high, toggle
// - pwm mode pin function: inactive, active, pwm waveform, single pulse
// - no pin change when the requested level equals the initial level
// - level bit: pwm active level, pulse start level, unused in timer
// - invert bit flips the output pin, ignored in timer/counter mode
// - clear select 0 clears on P match or overflow, 1 clears on A match
// - overflow clear under clear select 0 only when period is all zero
// - clear select bit is ignored in pwm and single pulse modes
// - counter readable as low byte and zero-padded high byte, read-only
// - compare A value held in two read/write bytes, reset to zero
// - period value held in two read/write bytes, reset to zero
// - compare mode with clear select 0 raises both A and P flags
// - clear select 1 clears on A match and never raises the P flag
// - compare A zero: counter overflows at maximum, no A flag
// - in compare mode only an A flag changes the pin, P leaves it alone
// - rising counter_on sets the pin to the initial level in compare mode
// - timer/counter mode does not drive the pin, counts like compare mode
// - rising counter_on clears the counter, falling stops and keeps it
// - pause bit holds the count, clearing it resumes from there
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

// ---------------------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------------------
`define PTC_ADDR_W 6
`define PTC_OFS_RUN_CONTROL 6'h00
`define PTC_OFS_MODE_PIN 6'h04
`define PTC_OFS_CNT_LOW 6'h08
`define PTC_OFS_CNT_HIGH 6'h0C
`define PTC_OFS_CMPA_LOW 6'h10
`define PTC_OFS_CMPA_HIGH 6'h14
`define PTC_OFS_PER_LOW 6'h18
`define PTC_OFS_PER_HIGH 6'h1C
`define PTC_OFS_FLAGS 6'h20

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define PTC_BIT_PAUSE 7
`define PTC_BIT_ON 3
`define PTC_BIT_MODE_HI 7
`define PTC_BIT_MODE_LO 6
`define PTC_BIT_PIN_HI 5
`define PTC_BIT_PIN_LO 4
`define PTC_BIT_LEVEL 3
`define PTC_BIT_INVERT 2
`define PTC_BIT_CLRSEL 0
`define PTC_BIT_FLAG_A 0
`define PTC_BIT_FLAG_P 1

// ---------------------------------------------------------------------------
// reset values, widths and bus answers
// ---------------------------------------------------------------------------
`define PTC_RST_BYTE 8'h00
`define PTC_CNT_W_DEFAULT 10
`define PTC_RESP_OKAY 2'h0
`define PTC_RESP_SLVERR 2'h2

`endif

// ==== inc/ptc_pkg.sv ====
// types shared by the periodic timer design
package ptc_pkg;

    typedef logic [5:0] ptc_addr_t;

    typedef enum logic [1:0] {
        PTC_MODE_CMP = 2'b00,
        PTC_MODE_UNDEF = 2'b01,
        PTC_MODE_PWM = 2'b10,
        PTC_MODE_TMR = 2'b11
    } ptc_mode_e;

    typedef enum logic [1:0] {
        PTC_PIN_KEEP = 2'b00,
        PTC_PIN_LOW = 2'b01,
        PTC_PIN_HIGH = 2'b10,
        PTC_PIN_TOGGLE = 2'b11
    } ptc_pin_e;

endpackage

// ==== hw/ptc_top.sv ====
// periodic timer with compare output, pwm/single pulse and axi4-lite registers
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ptc_consts.svh"

module ptc_top #(
    parameter int CNT_W = `PTC_CNT_W_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ptc_pkg::ptc_addr_t s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire ptc_pkg::ptc_addr_t s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic timer_output_pin,
    output logic timer_output_pin_oe
);
    import ptc_pkg::*;

    // -----------------------------------------------------------------------
    // state
    // -----------------------------------------------------------------------
    logic run_ctrl_reg_pause;
    logic counter_on_reg;
    logic [7:0] mode_pin_control_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cmp_a_reg;
    logic [CNT_W-1:0] period_reg;
    logic compare_a_flag_reg;
    logic compare_p_flag_reg;
    logic on_prev_reg;
    logic cm_level_reg;
    logic aw_have_reg;
    logic w_have_reg;
    ptc_addr_t aw_addr_reg;
    logic [7:0] w_byte_reg;
    logic w_lane_reg;

    // -----------------------------------------------------------------------
    // decoded fields and counter events
    // -----------------------------------------------------------------------
    ptc_mode_e mode_field;
    ptc_pin_e pin_function_field;
    logic output_level_control;
    logic output_invert;
    logic clear_source_select;
    logic on_rise;
    logic tick;
    logic [CNT_W-1:0] cnt_inc;
    logic a_hit;
    logic p_hit;
    logic single_pulse;
    logic cmp_like;
    logic clr_cnt;
    logic p_flag_set;
    logic pwm_raw;
    logic pin_next;
    logic pin_oe_next;
    logic wr_fire;
    logic wr_ok;
    logic [7:0] rd_byte;
    logic rd_ok;
    logic [15:0] cnt16;
    logic [15:0] cmp_a16;
    logic [15:0] period16;

    // mode and pin function decode
    assign mode_field = ptc_mode_e'(mode_pin_control_reg[`PTC_BIT_MODE_HI:
        `PTC_BIT_MODE_LO]);
    assign pin_function_field = ptc_pin_e'(
        mode_pin_control_reg[`PTC_BIT_PIN_HI:`PTC_BIT_PIN_LO]);
    assign output_level_control = mode_pin_control_reg[`PTC_BIT_LEVEL];
    assign output_invert = mode_pin_control_reg[`PTC_BIT_INVERT];
    assign clear_source_select = mode_pin_control_reg[`PTC_BIT_CLRSEL];

    // counter advances only while on, not paused and not restarting
    assign on_rise = counter_on_reg & ~on_prev_reg;
    assign tick = counter_on_reg & ~on_prev_reg ? 1'b0
                : counter_on_reg & ~run_ctrl_reg_pause;
    assign cnt_inc = CNT_W'(cnt_reg + 1'b1);

    // a match is the count reaching the compare value; zero never matches
    assign a_hit = tick && (cnt_inc == cmp_a_reg)
                   && (cmp_a_reg != '0);
    // period zero matches at the wrap from maximum, i.e. overflow
    assign p_hit = tick && (cnt_inc == period_reg);
    assign single_pulse = (mode_field == PTC_MODE_PWM)
                          && (pin_function_field == PTC_PIN_TOGGLE);
    assign cmp_like = (mode_field != PTC_MODE_PWM);

    // clear source choice, ignored in pwm and single pulse
    always_comb begin
        if (single_pulse) begin
            clr_cnt = 1'b0;
        end else if (cmp_like && clear_source_select) begin
            clr_cnt = a_hit;
        end else begin
            clr_cnt = p_hit;
        end
    end

    // p flag suppressed when compare A is the clear source
    assign p_flag_set = p_hit && !single_pulse
                        && !(cmp_like && clear_source_select);

    // pwm duty: active while the count is below compare A
    assign pwm_raw = counter_on_reg && (cnt_reg < cmp_a_reg);

    // -----------------------------------------------------------------------
    // counter
    // -----------------------------------------------------------------------
    // restart to zero, hold while off or paused, else count or clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
        end else if (on_rise) begin
            cnt_reg <= '0;
        end else if (tick) begin
            cnt_reg <= clr_cnt ? '0 : cnt_inc;
        end
    end

    // edge detector for counter_on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_prev_reg <= 1'b0;
        end else begin
            on_prev_reg <= counter_on_reg;
        end
    end

    // -----------------------------------------------------------------------
    // run control: pause and counter_on
    // -----------------------------------------------------------------------
    // single pulse ends on compare A by dropping counter_on; a software
    // write in the same cycle wins over that clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_ctrl_reg_pause <= 1'b0;
            counter_on_reg <= 1'b0;
        end else if (wr_fire && w_lane_reg
                     && aw_addr_reg == `PTC_OFS_RUN_CONTROL) begin
            run_ctrl_reg_pause <= w_byte_reg[`PTC_BIT_PAUSE];
            counter_on_reg <= w_byte_reg[`PTC_BIT_ON];
        end else if (single_pulse && a_hit) begin
            counter_on_reg <= 1'b0;
        end
    end

    // -----------------------------------------------------------------------
    // configuration and compare registers
    // -----------------------------------------------------------------------
    // byte writes; high bytes keep only the implemented bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_pin_control_reg <= `PTC_RST_BYTE;
            cmp_a_reg <= '0;
            period_reg <= '0;
        end else if (wr_fire && w_lane_reg) begin
            unique case (aw_addr_reg)
                `PTC_OFS_MODE_PIN: begin
                    mode_pin_control_reg <= w_byte_reg;
                end
                `PTC_OFS_CMPA_LOW: begin
                    cmp_a_reg[7:0] <= w_byte_reg;
                end
                `PTC_OFS_CMPA_HIGH: begin
                    cmp_a_reg[CNT_W-1:8] <= w_byte_reg[CNT_W-9:0];
                end
                `PTC_OFS_PER_LOW: begin
                    period_reg[7:0] <= w_byte_reg;
                end
                `PTC_OFS_PER_HIGH: begin
                    period_reg[CNT_W-1:8] <= w_byte_reg[CNT_W-9:0];
                end
                default: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // match flags
    // -----------------------------------------------------------------------
    // sticky flags, write one to clear, a new match wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_a_flag_reg <= 1'b0;
            compare_p_flag_reg <= 1'b0;
        end else begin
            if (a_hit) begin
                compare_a_flag_reg <= 1'b1;
            end else if (wr_fire && w_lane_reg
                         && aw_addr_reg == `PTC_OFS_FLAGS
                         && w_byte_reg[`PTC_BIT_FLAG_A]) begin
                compare_a_flag_reg <= 1'b0;
            end
            if (p_flag_set) begin
                compare_p_flag_reg <= 1'b1;
            end else if (wr_fire && w_lane_reg
                         && aw_addr_reg == `PTC_OFS_FLAGS
                         && w_byte_reg[`PTC_BIT_FLAG_P]) begin
                compare_p_flag_reg <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------------
    // output pin
    // -----------------------------------------------------------------------
    // compare mode level: initial level on start, then acted on by A match
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cm_level_reg <= 1'b0;
        end else if (on_rise) begin
            cm_level_reg <= output_level_control;
        end else if (a_hit && mode_field == PTC_MODE_CMP) begin
            unique case (pin_function_field)
                PTC_PIN_KEEP: cm_level_reg <= cm_level_reg;
                PTC_PIN_LOW: cm_level_reg <= 1'b0;
                PTC_PIN_HIGH: cm_level_reg <= 1'b1;
                PTC_PIN_TOGGLE: cm_level_reg <= ~cm_level_reg;
            endcase
        end
    end

    // pin level per mode before the register stage
    always_comb begin
        pin_next = 1'b0;
        pin_oe_next = 1'b1;
        unique case (mode_field)
            PTC_MODE_CMP, PTC_MODE_UNDEF: begin
                pin_next = cm_level_reg ^ output_invert;
            end
            PTC_MODE_PWM: begin
                unique case (pin_function_field)
                    PTC_PIN_KEEP: pin_next = ~output_level_control;
                    PTC_PIN_LOW: pin_next = output_level_control;
                    PTC_PIN_HIGH: pin_next = pwm_raw
                        ? output_level_control
                        : ~output_level_control;
                    PTC_PIN_TOGGLE: pin_next = counter_on_reg
                        ? output_level_control
                        : ~output_level_control;
                endcase
                pin_next = pin_next ^ output_invert;
            end
            PTC_MODE_TMR: begin
                pin_oe_next = 1'b0;
            end
        endcase
    end

    // registered pin drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_output_pin <= 1'b0;
            timer_output_pin_oe <= 1'b0;
        end else begin
            timer_output_pin <= pin_next;
            timer_output_pin_oe <= pin_oe_next;
        end
    end

    // -----------------------------------------------------------------------
    // axi4-lite write channel
    // -----------------------------------------------------------------------
    // address and data are caught separately, the write fires once both are
    // held and no response is pending
    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_ok = (aw_addr_reg[1:0] == 2'b00)
                   && (aw_addr_reg <= `PTC_OFS_FLAGS);

    // address catch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            s_axi_awready <= !aw_have_reg && !(s_axi_awvalid
                                                && s_axi_awready);
        end
    end

    // data catch; only byte lane 0 carries register data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_reg <= 1'b0;
            w_byte_reg <= `PTC_RST_BYTE;
            w_lane_reg <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
            s_axi_wready <= !w_have_reg && !(s_axi_wvalid
                                              && s_axi_wready);
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PTC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // -----------------------------------------------------------------------
    // axi4-lite read channel
    // -----------------------------------------------------------------------
    assign cnt16 = 16'(cnt_reg);
    assign cmp_a16 = 16'(cmp_a_reg);
    assign period16 = 16'(period_reg);

    // read mux; unimplemented high bits read as zero
    always_comb begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            `PTC_OFS_RUN_CONTROL: begin
                rd_byte[`PTC_BIT_PAUSE] = run_ctrl_reg_pause;
                rd_byte[`PTC_BIT_ON] = counter_on_reg;
            end
            `PTC_OFS_MODE_PIN: rd_byte = mode_pin_control_reg;
            `PTC_OFS_CNT_LOW: rd_byte = cnt16[7:0];
            `PTC_OFS_CNT_HIGH: rd_byte = cnt16[15:8];
            `PTC_OFS_CMPA_LOW: rd_byte = cmp_a16[7:0];
            `PTC_OFS_CMPA_HIGH: rd_byte = cmp_a16[15:8];
            `PTC_OFS_PER_LOW: rd_byte = period16[7:0];
            `PTC_OFS_PER_HIGH: rd_byte = period16[15:8];
            `PTC_OFS_FLAGS: begin
                rd_byte[`PTC_BIT_FLAG_A] = compare_a_flag_reg;
                rd_byte[`PTC_BIT_FLAG_P] = compare_p_flag_reg;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // read address accept and data return
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PTC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_ok ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready
                             && s_axi_arvalid;
        end
    end

endmodule // ptc_top
`default_nettype wire

// ==== testbench/ptc_top_properties.sv ====
// bus and pin checks for the periodic timer top
`timescale 1ns/10ps
`default_nettype none

module ptc_top_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_output_pin_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // handshake steps
    // ------------------------------------------------------------
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_upper_zero: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while data pending");
    a_resp_codes: assert property (s_axi_bvalid
        |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("bad write response");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn
        |=> !s_axi_bvalid && !s_axi_rvalid && !timer_output_pin_oe)
        else $error("outputs active in reset");
endmodule // ptc_top_properties

bind ptc_top ptc_top_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .timer_output_pin_oe);
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the periodic timer
`timescale 1ns/10ps
`default_nettype none
`include "ptc_consts.svh"

module tb;
    import ptc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    ptc_addr_t awaddr = '0;
    ptc_addr_t araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = '0;
    logic awready, wready, bvalid, arready, rvalid, pin, oe;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    logic [31:0] rdata;
    logic [7:0] rd_v, v;
    int err_total = 0;
    int checks = 0;

    ptc_top #(.CNT_W(10)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_output_pin(pin),
        .timer_output_pin_oe(oe));

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 64) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, n, 0);
            end_sim();
        end
    endtask
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic wr(input ptc_addr_t a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while ((awvalid || wvalid) && n < 64);
        do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 64);
        tmo(n);
        wr_r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input ptc_addr_t a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 64);
        arvalid <= 1'b0;
        do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 64);
        tmo(n);
        rd_v = rdata[7:0];
        rd_r = rresp;
        rready <= 1'b0;
    endtask
    task automatic run(input logic [7:0] mp, input logic [7:0] a,
            input logic [7:0] p);
        wr(`PTC_OFS_RUN_CONTROL, 8'h00);
        wr(`PTC_OFS_CMPA_LOW, a);
        wr(`PTC_OFS_PER_LOW, p);
        wr(`PTC_OFS_FLAGS, 8'h03);
        wr(`PTC_OFS_MODE_PIN, mp & 8'hFD);
        wr(`PTC_OFS_RUN_CONTROL, 8'h08);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        for (int a = 4; a <= 32; a += 4) begin
            rd(ptc_addr_t'(a));
            chk(rd_v, 8'h00);
        end
        wr(`PTC_OFS_CMPA_HIGH, 8'hFF);
        rd(`PTC_OFS_CMPA_HIGH);
        chk(rd_v, 8'h03);
        wr(`PTC_OFS_PER_HIGH, 8'hFF);
        rd(`PTC_OFS_PER_HIGH);
        chk(rd_v, 8'h03);
        wr(`PTC_OFS_CNT_LOW, 8'h5A);
        rd(`PTC_OFS_CNT_LOW);
        chk(rd_v, 8'h00);
        wr(`PTC_OFS_MODE_PIN, 8'hFD);
        rd(`PTC_OFS_MODE_PIN);
        chk(rd_v, 8'hFD);
        rd(6'h24);
        chk(8'(rd_r), 8'h02);
        wr(6'h24, 8'h00);
        chk(8'(wr_r), 8'h02);
        wr(`PTC_OFS_CMPA_HIGH, 8'h00);
        wr(`PTC_OFS_PER_HIGH, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_cmp();
        logic [1:0] io;
        logic oc, inv, e;
        int n;
        for (int i = 0; i < 8; i++) begin
            io = i[1:0];
            oc = i[2];
            inv = i[0] ^ i[2];
            run({2'b00, io, oc, inv, 2'b00}, 8'h20, 8'h00);
            repeat (3) @(posedge aclk);
            chk(8'(pin), 8'(oc ^ inv));
            chk(8'(oe), 8'h01);
            n = 0;
            do begin
                rd(`PTC_OFS_FLAGS);
                n++;
            end while (rd_v[0] !== 1'b1 && n < 64);
            tmo(n);
            e = (io == 2'b01) ? 1'b0 : (io == 2'b10) ? 1'b1 : oc ^ (&io);
            chk(8'(pin), 8'(e ^ inv));
            chk(8'(rd_v[1]), 8'h00);
        end
        $display("test compare done");
    endtask
    task automatic t_clr();
        run(8'h01, 8'h10, 8'h08);
        repeat (80) @(posedge aclk);
        rd(`PTC_OFS_FLAGS);
        chk(rd_v, 8'h01);
        run(8'h00, 8'h10, 8'h30);
        repeat (100) @(posedge aclk);
        rd(`PTC_OFS_FLAGS);
        chk(rd_v, 8'h03);
        rd(`PTC_OFS_CNT_LOW);
        chk(8'(rd_v < 8'h30), 8'h01);
        wr(`PTC_OFS_RUN_CONTROL, 8'h88);
        rd(`PTC_OFS_CNT_LOW);
        v = rd_v;
        repeat (20) @(posedge aclk);
        rd(`PTC_OFS_CNT_LOW);
        chk(rd_v, v);
        wr(`PTC_OFS_RUN_CONTROL, 8'h08);
        repeat (10) @(posedge aclk);
        rd(`PTC_OFS_CNT_LOW);
        chk(8'(rd_v != v), 8'h01);
        wr(`PTC_OFS_RUN_CONTROL, 8'h00);
        rd(`PTC_OFS_CNT_LOW);
        v = rd_v;
        repeat (10) @(posedge aclk);
        rd(`PTC_OFS_CNT_LOW);
        chk(rd_v, v);
        run(8'hC0, 8'h00, 8'h00);
        repeat (1100) @(posedge aclk);
        rd(`PTC_OFS_FLAGS);
        chk(rd_v, 8'h02);
        $display("test clear done");
    endtask
    task automatic t_modes();
        logic [7:0] h;
        run(8'hC0, 8'h10, 8'h00);
        repeat (30) @(posedge aclk);
        chk(8'(oe), 8'h00);
        rd(`PTC_OFS_FLAGS);
        chk(rd_v, 8'h01);
        for (int j = 0; j < 4; j++) begin
            run({3'b100, j[0], j[1], 3'b000}, 8'h10, 8'h20);
            repeat (4) @(posedge aclk);
            chk(8'(pin), 8'(j[0] ? j[1] : !j[1]));
        end
        // pwm waveform, period 32 duty 8, clear select set but ignored
        for (int k = 0; k < 2; k++) begin
            run({5'b10101, k[0], 2'b01}, 8'h08, 8'h20);
            repeat (2) @(posedge aclk);
            h = 8'h00;
            repeat (64) begin
                @(posedge aclk);
                h = h + 8'(pin);
            end
            chk(h, k[0] ? 8'h30 : 8'h10);
        end
        // single pulse: high from start, ended by the compare A match
        run(8'hB8, 8'h10, 8'h00);
        @(posedge aclk);
        chk(8'(pin), 8'h01);
        repeat (30) @(posedge aclk);
        chk(8'(pin), 8'h00);
        rd(`PTC_OFS_RUN_CONTROL);
        chk(rd_v, 8'h00);
        rd(`PTC_OFS_CNT_LOW);
        chk(rd_v, 8'h10);
        $display("test modes done");
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_cmp();
        t_clr();
        t_modes();
        end_sim();
    end
endmodule // tb
`default_nettype wire
